// file: design/shrhc_consts.vh
// Purpose: constants for the shared ram handshake controller
// Assumes: 25 MHz system clock, 8-bit data ram words, 8-bit addresses
// Notes: flag words live at fixed ram addresses inside each data ram
`ifndef SHRHC_CONSTS_VH
`define SHRHC_CONSTS_VH
// ---------------------------------------------------------------
// flag locations and encodings
// ---------------------------------------------------------------
`define SHRHC_ADDR_OUT_A 8'h7E
`define SHRHC_ADDR_IN_A 8'h7F
`define SHRHC_ADDR_OUT_B 8'hFE
`define SHRHC_ADDR_IN_B 8'hFF
`define SHRHC_IN_IDLE 2'h0
`define SHRHC_IN_REQ 2'h1
`define SHRHC_IN_FULL 2'h3
`define SHRHC_OUT_READY 1'h1
`define SHRHC_OUT_CLEAR 1'h0
// ---------------------------------------------------------------
// block layout: write block 4..87, read block 4..38
// ---------------------------------------------------------------
`define SHRHC_BLK_BASE_A 8'h00
`define SHRHC_BLK_BASE_B 8'h80
`define SHRHC_WR_FIRST 8'h04
`define SHRHC_WR_LAST 8'h57
`define SHRHC_RD_FIRST 8'h04
`define SHRHC_RD_LAST 8'h26
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SHRHC_CLK_HZ 25000000
`define SHRHC_SLOT_NS 7812500
`define SHRHC_SLOT_CYC ((`SHRHC_SLOT_NS / 40))
`define SHRHC_RESET_ROW 4'h0
`define SHRHC_RESET_COL 4'hF
`define SHRHC_WORDS_PER_SLOT 3'h4
`endif

// file: design/shrhc_ctrl.v
// Purpose: data steering controller side of the shared data ram handshake
// Assumes: one clock; ram grants and ram read data are on sys_clk
// Notes: two processors served; the search ends after p2B and has no third processor position
//   the ram port is registered, so a grant seen at one edge covers the
//   access presented during the following cycle
//   write-in words are spaced at least one cycle apart so the input source
//   can follow the registered take strobe; this halves the fill rate
//
// Operation
// - master reset starts processors at row 0 column 15
// - cycle reset pulse every 7.8125 ms slot
// - one header and three data words per slot
// - controller sets input field 11 after fill
// - no read-out unless output ready is 1
// - controller clears output ready after read-out
// - two areas, results read from same area
// - processor access wins on its ram cycles
// - transfers stall per cycle, resume without loss
// - processors independent, data only through ram
// - seven service levels, restart at level two
// - search p1A, p1B, p2A, p2B, then p3; here the search ends after p2B
// - flag words at 126, 127, 254, 255
// - one processor, one direction per block
`include "shrhc_consts.vh"

module shrhc_ctrl #(
  parameter NPROC = 2,
  parameter SLOT_CYC = `SHRHC_SLOT_CYC
) (
  input wire sys_clk,
  input wire rst_n,
  // processor side, per processor packed
  input wire [NPROC-1:0] up_mem_req,
  output reg [NPROC-1:0] up_master_reset,
  output reg [NPROC-1:0] up_cycle_reset,
  output reg [3:0] up_start_row,
  output reg [3:0] up_start_col,
  // ram port owned by the controller, one shared address/data bus
  output reg [NPROC-1:0] ram_sel,
  output reg [7:0] ram_addr,
  output reg ram_we,
  output reg [7:0] ram_wdata,
  input wire [8*NPROC-1:0] ram_rdata,
  // unit-side sources and sinks
  input wire slot_start,
  input wire synd_ready,
  input wire [7:0] in_data,
  output reg in_take,
  output reg [7:0] out_data,
  output reg out_valid,
  output reg [2:0] level,
  output reg [2:0] words_in_slot
);

  // ---------------------------------------------------------------
  // states and levels
  // ---------------------------------------------------------------
  // engine states; binary codes, one level served at a time
  localparam ST_IDLE = 3'h0;
  localparam ST_POLL = 3'h1;
  localparam ST_EVAL = 3'h2;
  localparam ST_XFER = 3'h3;
  localparam ST_FLAG = 3'h4;
  // service levels; level 1 belongs to the external slot event and is
  // only entered through a cycle reset
  localparam LV_EXT = 3'h1;
  localparam LV_RD = 3'h2;
  localparam LV_ENC_O = 3'h3;
  localparam LV_ENC_I = 3'h4;
  localparam LV_SYN_O = 3'h5;
  localparam LV_WR = 3'h6;
  localparam LV_SYN_I = 3'h7;
  localparam [22:0] SLOT_LAST = SLOT_CYC - 1;

  // ---------------------------------------------------------------
  // slot start pin synchroniser and slot watchdog
  // ---------------------------------------------------------------
  reg slot_s1_reg; // first stage, read only by the second
  reg slot_s2_reg;
  reg slot_s3_reg; // edge detect history
  reg [22:0] slot_cnt_reg;
  reg [NPROC-1:0] por_reg; // master reset held for first cycles
  wire slot_edge;

  assign slot_edge = slot_s2_reg & ~slot_s3_reg;

  // slot timer free runs; an external slot edge realigns it
  // the free-running count keeps cycle resets coming even if the slot pin
  // stops, so a hung processor is always recovered within one slot
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot_s1_reg <= 1'b0;
      slot_s2_reg <= 1'b0;
      slot_s3_reg <= 1'b0;
      slot_cnt_reg <= 23'h000000;
      por_reg <= {NPROC{1'b1}};
      up_master_reset <= {NPROC{1'b1}};
      up_cycle_reset <= {NPROC{1'b0}};
      up_start_row <= `SHRHC_RESET_ROW;
      up_start_col <= `SHRHC_RESET_COL;
    end
    else
    begin
      slot_s1_reg <= slot_start;
      slot_s2_reg <= slot_s1_reg;
      slot_s3_reg <= slot_s2_reg;
      por_reg <= {NPROC{1'b0}};
      up_master_reset <= por_reg;
      up_start_row <= `SHRHC_RESET_ROW;
      up_start_col <= `SHRHC_RESET_COL;
      if (slot_edge || slot_cnt_reg == SLOT_LAST)
      begin
        slot_cnt_reg <= 23'h000000;
        up_cycle_reset <= {NPROC{1'b1}};
      end
      else
      begin
        slot_cnt_reg <= slot_cnt_reg + 23'h000001;
        up_cycle_reset <= {NPROC{1'b0}};
      end
    end
  end

  // same condition as the pulse above, seen by the engine in the same cycle
  // so a partial transfer is dropped as the pulse is launched
  wire cyc_rst = slot_edge || slot_cnt_reg == SLOT_LAST;

  // ---------------------------------------------------------------
  // service engine
  // ---------------------------------------------------------------
  // engine registers; cand_reg is the search position, its low bit the area
  reg [2:0] state_reg;
  reg [2:0] poll_idx_reg; // {proc, area, in/out} slot, cleared at reset and never loaded
  reg [1:0] cand_reg; // {proc, area} under test
  reg dir_rd_reg; // 1 read-out, 0 write-in
  reg [7:0] addr_reg;
  reg pend_reg; // an access is in flight
  wire [7:0] rd_mux;
  wire granted;
  wire proc_now;

  assign proc_now = cand_reg[1];
  assign rd_mux = ram_rdata[8*proc_now +: 8];
  // a processor request on this cycle takes the next ram cycle from us
  assign granted = ~up_mem_req[proc_now];

  // one level at a time; only one processor and one direction per block
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      level <= LV_RD;
      cand_reg <= 2'h0;
      dir_rd_reg <= 1'b0;
      addr_reg <= 8'h00;
      pend_reg <= 1'b0;
      poll_idx_reg <= 3'h0;
      ram_sel <= {NPROC{1'b0}};
      ram_addr <= 8'h00;
      ram_we <= 1'b0;
      ram_wdata <= 8'h00;
      in_take <= 1'b0;
      out_data <= 8'h00;
      out_valid <= 1'b0;
      words_in_slot <= 3'h0;
    end
    else if (cyc_rst)
    begin
      // abandon whatever is partway through
      state_reg <= ST_IDLE;
      level <= LV_EXT;
      pend_reg <= 1'b0;
      ram_sel <= {NPROC{1'b0}};
      ram_we <= 1'b0;
      in_take <= 1'b0;
      out_valid <= 1'b0;
      words_in_slot <= 3'h0;
    end
    else
    begin
      in_take <= 1'b0;
      out_valid <= 1'b0;
      ram_we <= 1'b0;
      case (state_reg)
        // idle: pick the next level; only ram levels start a search
        // the write-in level also needs syndrome data and slot budget, else it passes through
        ST_IDLE:
        begin
          // levels without ram work are handed to other units; pass through
          if (level == LV_RD || (level == LV_WR && synd_ready &&
              words_in_slot != `SHRHC_WORDS_PER_SLOT))
          begin
            dir_rd_reg <= (level == LV_RD);
            cand_reg <= 2'h0;
            state_reg <= ST_POLL;
          end
          else
            level <= (level == LV_SYN_I) ? LV_RD : level + 3'h1;
        end
        // poll: present the flag address until a cycle is ours
        // a stolen cycle simply repeats the same flag read
        ST_POLL:
        begin
          // read the flag word for this candidate
          ram_sel <= {{(NPROC-1){1'b0}}, 1'b1} << cand_reg[1];
          ram_addr <= dir_rd_reg ?
            (cand_reg[0] ? `SHRHC_ADDR_OUT_B : `SHRHC_ADDR_OUT_A) :
            (cand_reg[0] ? `SHRHC_ADDR_IN_B : `SHRHC_ADDR_IN_A);
          if (granted)
            state_reg <= ST_EVAL;
        end
        // eval: the flag word is on the read lane of the selected ram
        // a hit starts the block, a miss moves to the next search position, a miss at p2B ends the search
        ST_EVAL:
        begin
          if (dir_rd_reg ? (rd_mux[0] == `SHRHC_OUT_READY) :
              (rd_mux[1:0] == `SHRHC_IN_REQ))
          begin
            addr_reg <= (cand_reg[0] ? `SHRHC_BLK_BASE_B : `SHRHC_BLK_BASE_A) +
              (dir_rd_reg ? `SHRHC_RD_FIRST : `SHRHC_WR_FIRST);
            state_reg <= ST_XFER;
          end
          else if (cand_reg == 2'h3)
          begin
            // no request; third processor positions are never populated
            state_reg <= ST_IDLE;
            level <= level + 3'h1;
          end
          else
          begin
            cand_reg <= cand_reg + 2'h1;
            state_reg <= ST_POLL;
          end
        end
        // block transfer: one word per cycle the ram is ours
        // a write word is not issued while in_take still stands, so the
        // registered take strobe never lets one input word land twice
        ST_XFER:
        begin
          // address stays put while the processor holds the ram
          ram_addr <= addr_reg;
          if (pend_reg && dir_rd_reg)
          begin
            out_data <= rd_mux;
            out_valid <= 1'b1;
          end
          pend_reg <= granted && !in_take;
          if (granted && !in_take)
          begin
            ram_we <= ~dir_rd_reg;
            ram_wdata <= in_data;
            in_take <= ~dir_rd_reg;
            if ({1'b0, addr_reg[6:0]} == (dir_rd_reg ? `SHRHC_RD_LAST : `SHRHC_WR_LAST))
              state_reg <= ST_FLAG;
            else
              addr_reg <= addr_reg + 8'h01;
          end
        end
        // flag: hand on the last read word, then write the closing flag
        // the block counts as done only once the flag write is granted
        ST_FLAG:
        begin
          if (pend_reg && dir_rd_reg)
          begin
            out_data <= rd_mux;
            out_valid <= 1'b1;
          end
          pend_reg <= 1'b0;
          ram_addr <= dir_rd_reg ?
            (cand_reg[0] ? `SHRHC_ADDR_OUT_B : `SHRHC_ADDR_OUT_A) :
            (cand_reg[0] ? `SHRHC_ADDR_IN_B : `SHRHC_ADDR_IN_A);
          ram_wdata <= dir_rd_reg ? {7'h00, `SHRHC_OUT_CLEAR} :
            {6'h00, `SHRHC_IN_FULL};
          // the flag is written only after the last read word has gone out
          if (granted && !pend_reg)
          begin
            ram_we <= 1'b1;
            state_reg <= ST_IDLE;
            level <= LV_RD;
            if (!dir_rd_reg)
              words_in_slot <= words_in_slot + 3'h1;
          end
        end
        // unused codes fall back to idle
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // shrhc_ctrl

// file: verif/shrhc_ram_model.sv
// Purpose: pair of shared data rams behind the controller
// Assumes: a processor owns its ram on the cycle after each cycle its up_mem_req is high
// Notes: read data follows this cycle's address; a request seen at one edge holds
//   the ram for the next cycle; the bench writes flags directly
module shrhc_ram_model #(
  parameter NPROC = 2
) (
  input wire logic sys_clk,
  input wire logic [NPROC-1:0] up_mem_req,
  input wire logic [NPROC-1:0] ram_sel,
  input wire logic [7:0] ram_addr,
  input wire logic ram_we,
  input wire logic [7:0] ram_wdata,
  output logic [8*NPROC-1:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [NPROC][256]; // one data ram per processor, flags idle at start
  logic [NPROC-1:0] req_q; // processor claim on the current cycle
  initial
  begin
    foreach (mem[p, a]) mem[p][a] = 8'h00;
  end
  // a write on a stolen cycle is lost, so a controller that does not stall shows up
  always @(posedge sys_clk)
  begin
    req_q <= up_mem_req;
    for (int p = 0; p < NPROC; p++)
      if (ram_we && ram_sel[p] && !req_q[p]) mem[p][ram_addr] <= ram_wdata;
  end
  // while the processor holds its ram the lane shows garbage, not stale data
  always_comb
    for (int p = 0; p < NPROC; p++)
      ram_rdata[8*p +: 8] = req_q[p] ? ~mem[p][ram_addr] : mem[p][ram_addr];
endmodule // shrhc_ram_model

// file: verif/shrhc_ctrl_sva.sv
// Purpose: port checks for the data steering controller
// Assumes: single clock domain, async active-low reset
// Notes: bound to every shrhc_ctrl instance
module shrhc_ctrl_sva #(
  parameter NPROC = 2,
  parameter SLOT_CYC = 600
) (
  input wire sys_clk,
  input wire rst_n,
  input wire [NPROC-1:0] up_mem_req,
  input wire [NPROC-1:0] up_master_reset,
  input wire [NPROC-1:0] up_cycle_reset,
  input wire [3:0] up_start_row,
  input wire [3:0] up_start_col,
  input wire [NPROC-1:0] ram_sel,
  input wire [7:0] ram_addr,
  input wire ram_we,
  input wire out_valid,
  input wire [2:0] level,
  input wire [2:0] words_in_slot
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // processor keeps the selected ram for two cycles running
  sequence stall2_s;
    (|(ram_sel & up_mem_req))[*2];
  endsequence
  a_start_loc: assert property (up_start_row == 4'h0 && up_start_col == 4'hF) else $error("bad restart");
  a_master_short: assert property ($rose(rst_n) |-> ##[2:4] (up_master_reset == 0)) else $error("master long");
  a_master_once: assert property ((up_master_reset == 0) |=> (up_master_reset == 0)) else $error("master again");
  a_cycle_pulse: assert property ((up_cycle_reset != 0) |=> (up_cycle_reset == 0)) else $error("cycle wide");
  a_cycle_gap: assert property ($rose(up_cycle_reset[0]) |=> (up_cycle_reset == 0)[*8]) else $error("cycle gap");
  a_cycle_level: assert property ((up_cycle_reset != 0) |-> ##[0:3] (level == 3'h2)) else $error("no restart");
  a_stall_nowrite: assert property (stall2_s |=> !ram_we) else $error("write on stolen cycle");
  a_sel_onehot: assert property ($onehot0(ram_sel)) else $error("two rams selected");
  a_slot_words: assert property (words_in_slot <= 3'h4) else $error("too many words");
  a_one_dir: assert property (ram_we |-> !out_valid) else $error("both directions");
endmodule // shrhc_ctrl_sva
bind shrhc_ctrl shrhc_ctrl_sva #(.NPROC(NPROC), .SLOT_CYC(SLOT_CYC)) shrhc_ctrl_sva_i (.sys_clk, .rst_n,
  .up_mem_req, .up_master_reset, .up_cycle_reset, .up_start_row, .up_start_col, .ram_sel, .ram_addr,
  .ram_we, .out_valid, .level, .words_in_slot);

// file: verif/shrhc_ctrl_bench.sv
// Purpose: self-checking bench for the data steering controller
// Assumes: slot length shortened to 600 cycles
// Notes: processor steals two of every three cycles while stall is set
`include "shrhc_consts.vh"
module shrhc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOTC = 600; // short slot keeps the run brief
  logic sys_clk = 0, rst_n = 0, slot_start = 0, synd_ready = 0, in_take, out_valid, ram_we, stall = 0;
  logic [1:0] up_mem_req = 0, up_master_reset, up_cycle_reset, ram_sel;
  logic [3:0] up_start_row, up_start_col;
  logic [7:0] ram_addr, ram_wdata, out_data, in_data = 8'h10, first_out = 8'h00, last_out = 8'h00;
  logic [15:0] ram_rdata;
  logic [2:0] level, words_in_slot;
  int num_errors = 0, num_checks = 0, takes = 0, outs = 0, cyc = 0, t0;
  shrhc_ctrl #(.NPROC(2), .SLOT_CYC(SLOTC)) shrhc_ctrl_i (.sys_clk, .rst_n, .up_mem_req, .up_master_reset,
    .up_cycle_reset, .up_start_row, .up_start_col, .ram_sel, .ram_addr, .ram_we, .ram_wdata, .ram_rdata,
    .slot_start, .synd_ready, .in_data, .in_take, .out_data, .out_valid, .level, .words_in_slot);
  shrhc_ram_model #(.NPROC(2)) shrhc_ram_model_i (.sys_clk, .up_mem_req, .ram_sel, .ram_addr, .ram_we,
    .ram_wdata, .ram_rdata);
  initial forever #20 sys_clk = ~sys_clk;
  // input words count up from 8'h10; processor steals two of three cycles when stalling
  always @(posedge sys_clk)
  begin
    cyc++;
    takes += in_take;
    if (out_valid && outs == 0) first_out = out_data;
    if (out_valid) last_out = out_data;
    outs += out_valid;
    #1;
    in_data = 8'h10 + takes[7:0];
    up_mem_req = (stall && cyc % 3 != 0) ? 2'h3 : 2'h0;
  end
  task automatic check(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end
  endtask
  task automatic wait_slot();
    int n = 0;
    do @(posedge sys_clk); while (!up_cycle_reset[0] && ++n < SLOTC + 20);
    #1;
  endtask
  task automatic wait_mem(input int p, input logic [7:0] a, v);
    for (int i = 0; i < 500 && shrhc_ram_model_i.mem[p][a] !== v; i++) @(posedge sys_clk);
  endtask
  task automatic t_write();
    wait_slot();
    takes = 0;
    stall = 1;
    synd_ready = 1;
    shrhc_ram_model_i.mem[0][`SHRHC_ADDR_IN_A] = 8'h01;
    wait_mem(0, `SHRHC_ADDR_IN_A, 8'h03);
    stall = 0;
    check(shrhc_ram_model_i.mem[0][`SHRHC_ADDR_IN_A], 16'h0003);
    check(16'(takes), 16'd84);
    check(shrhc_ram_model_i.mem[0][4], 16'h0010);
    check(shrhc_ram_model_i.mem[0][87], 16'h0063);
    check(shrhc_ram_model_i.mem[1][4], 16'h0000);
    shrhc_ram_model_i.mem[0][`SHRHC_ADDR_IN_A] = 8'h00;
  endtask
  task automatic t_read();
    wait_slot();
    outs = 0;
    repeat (100) @(posedge sys_clk);
    check(16'(outs), 16'd0);
    #1 shrhc_ram_model_i.mem[0][`SHRHC_ADDR_OUT_A] = 8'h01;
    wait_mem(0, `SHRHC_ADDR_OUT_A, 8'h00);
    repeat (2) @(posedge sys_clk);
    check(shrhc_ram_model_i.mem[0][`SHRHC_ADDR_OUT_A], 16'h0000);
    check(16'(outs), 16'd35);
    check(16'(first_out), 16'h0010);
    check(16'(last_out), 16'h0032);
  endtask
  task automatic t_order();
    wait_slot();
    takes = 0;
    shrhc_ram_model_i.mem[1][`SHRHC_ADDR_IN_B] = 8'h01;
    shrhc_ram_model_i.mem[0][`SHRHC_ADDR_IN_B] = 8'h01;
    wait_mem(0, `SHRHC_ADDR_IN_B, 8'h03);
    check(shrhc_ram_model_i.mem[1][`SHRHC_ADDR_IN_B], 16'h0001);
    check(shrhc_ram_model_i.mem[0][8'h84], 16'h0010);
    check(shrhc_ram_model_i.mem[0][8'h85], 16'h0011);
  endtask
  task automatic t_sync();
    wait_slot();
    repeat (50) @(posedge sys_clk);
    #1 slot_start = 1;
    repeat (4) @(posedge sys_clk);
    check(16'(up_cycle_reset), 16'h0003);
    #1 slot_start = 0;
    t0 = cyc;
    wait_slot();
    check(16'(cyc - t0), 16'(SLOTC));
  endtask
  task automatic t_slot();
    wait_slot();
    t0 = cyc;
    wait_slot();
    check(16'(cyc - t0), 16'(SLOTC));
  endtask
  task automatic conclude();
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    check({up_master_reset, up_start_col, level}, 16'h01FA);
    #1 rst_n = 1;
    repeat (4) @(posedge sys_clk);
    check({up_master_reset, up_start_row}, 16'h0000);
    t_write();
    t_read();
    t_order();
    t_slot();
    t_sync();
    conclude();
  end
  initial
  begin
    #(40 * 8000);
    num_errors++;
    conclude();
  end
endmodule // shrhc_ctrl_bench
